// >>> wat_defs.vh
// constants for the week alarm timer core
`ifndef WAT_DEFS_VH
`define WAT_DEFS_VH

// register offsets (byte addresses)
`define WAT_OFF_CONTROL 12'h000
`define WAT_OFF_COUNT 12'h004
`define WAT_OFF_MATCH 12'h008
`define WAT_OFF_PRESCALE 12'h00c
`define WAT_OFF_IRQ_STATUS 12'h010
`define WAT_OFF_IRQ_MASK 12'h014
`define WAT_OFF_WAKE_STATUS 12'h018

// control register fields
`define WAT_CTL_RUN_BIT 0
`define WAT_CTL_WAKE_EN_BIT 6

// interrupt status fields
`define WAT_IRQ_ALARM_BIT 0
`define WAT_IRQ_TICK_BIT 1
`define WAT_IRQ_WIDTH 2

// reset values
`define WAT_RST_CONTROL 7'h01
`define WAT_RST_COUNT 28'h0000000
`define WAT_RST_MATCH 28'h0ffffff
`define WAT_RST_PRESCALE 15'h0000
`define WAT_RST_IRQ_MASK 2'h0

// prescale terminal value and slow-tick divider
`define WAT_PRESCALE_MAX 15'h7fff
`define WAT_PCLK_HZ 250000000
`define WAT_SLOW_HZ 32768
// pclk cycles per 32.768 kHz tick, rounded down
`define WAT_SLOW_DIV (`WAT_PCLK_HZ / `WAT_SLOW_HZ)

`endif

// >>> wat_slow_tick.v
// divider that makes the 32.768 kHz enable pulse from pclk
`default_nettype none

module wat_slow_tick #(
  parameter DIV = 7629 // pclk cycles per slow tick
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  output reg tick_q // one-cycle slow enable
);
  reg [15:0] cnt_q;

  // ***************************************
  // free-running divider
  // ***************************************
  // kept running always, so slow-domain timing stays phase steady
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> wat_flag.v
// sticky flag, set wins over write-one clear
`default_nettype none

module wat_flag (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire set, // hardware event
  input wire clr, // software clear
  output reg flag_q // sticky state
);
  // ***************************************
  // flag storage
  // ***************************************
  // set has priority so no event is lost on a clearing write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> wat_core.v
// week alarm timer core: prescaler, seconds counter, match, apb registers
//
// Chosen here: register access over APB.
`include "wat_defs.vh"
`default_nettype none

module wat_core #(
  parameter SLOW_DIV = `WAT_SLOW_DIV // pclk cycles per 32.768 kHz step
) (
  input wire pclk, // system clock, 250 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb byte strobes
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error
  output reg irq_q, // level interrupt
  output reg wake_event_q // wake (power-up) event
);
  // ***************************************
  // state
  // ***************************************
  // software-visible registers and counters
  reg count_run_q;
  reg wake_event_output_enable_q;
  reg [27:0] count_q;
  reg [27:0] match_q;
  reg [14:0] prescale_q;
  reg [27:0] pend_count_q;
  reg pend_valid_q;
  reg [1:0] irq_mask_q;
  reg wake_status_q;
  reg alarm_q;
  reg step_q;
  // enables, strobes and flags
  wire slow_tick;
  wire [1:0] irq_flags;
  wire wr_acc;
  wire setup_acc;
  wire rd_setup;
  wire addr_ok;
  wire sec_step;
  wire wr_ctl;
  wire wr_cnt;
  wire wr_mat;
  wire wr_msk;
  wire wr_sts;
  wire wr_wks;
  reg [31:0] rdata_d;

  // ***************************************
  // slow enable and sticky flags
  // ***************************************
  wat_slow_tick #(
    .DIV(SLOW_DIV)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_q(slow_tick)
  );

  wat_flag u_alarm_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(alarm_q),
    .clr(wr_sts & pwdata[`WAT_IRQ_ALARM_BIT]),
    .flag_q(irq_flags[`WAT_IRQ_ALARM_BIT])
  );

  wat_flag u_tick_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(sec_step),
    .clr(wr_sts & pwdata[`WAT_IRQ_TICK_BIT]),
    .flag_q(irq_flags[`WAT_IRQ_TICK_BIT])
  );

  // ***************************************
  // apb decode
  // ***************************************
  // zero-wait slave: every access finishes in its first access cycle
  assign wr_acc = psel & penable & pwrite;
  // setup strobes: read data and the error flag are loaded one edge early
  assign setup_acc = psel & ~penable;
  assign rd_setup = setup_acc & ~pwrite;
  assign addr_ok = (paddr == `WAT_OFF_CONTROL) | (paddr == `WAT_OFF_COUNT) |
                   (paddr == `WAT_OFF_MATCH) | (paddr == `WAT_OFF_PRESCALE) |
                   (paddr == `WAT_OFF_IRQ_STATUS) | (paddr == `WAT_OFF_IRQ_MASK) |
                   (paddr == `WAT_OFF_WAKE_STATUS);
  // control, mask and status writes need byte lane 0 strobed; count and match writes ignore pstrb
  assign wr_ctl = wr_acc & pstrb[0] & (paddr == `WAT_OFF_CONTROL);
  assign wr_cnt = wr_acc & (paddr == `WAT_OFF_COUNT);
  assign wr_mat = wr_acc & (paddr == `WAT_OFF_MATCH);
  assign wr_msk = wr_acc & pstrb[0] & (paddr == `WAT_OFF_IRQ_MASK);
  assign wr_sts = wr_acc & pstrb[0] & (paddr == `WAT_OFF_IRQ_STATUS);
  assign wr_wks = wr_acc & pstrb[0] & (paddr == `WAT_OFF_WAKE_STATUS);

  // seconds step: prescaler moving 0 -> 1 while running
  assign sec_step = step_q;

  // ***************************************
  // read mux
  // ***************************************
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `WAT_OFF_CONTROL: begin
        rdata_d[`WAT_CTL_RUN_BIT] = count_run_q;
        rdata_d[`WAT_CTL_WAKE_EN_BIT] = wake_event_output_enable_q;
      end
      `WAT_OFF_COUNT: rdata_d[27:0] = count_q;
      `WAT_OFF_MATCH: rdata_d[27:0] = match_q;
      `WAT_OFF_PRESCALE: rdata_d[14:0] = prescale_q;
      `WAT_OFF_IRQ_STATUS: rdata_d[`WAT_IRQ_WIDTH-1:0] = irq_flags;
      `WAT_OFF_IRQ_MASK: rdata_d[`WAT_IRQ_WIDTH-1:0] = irq_mask_q;
      `WAT_OFF_WAKE_STATUS: rdata_d[0] = wake_status_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // ***************************************
  // apb response
  // ***************************************
  // ready is a constant-high flop so the port still comes from a register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end

  // error decided at setup, so it stands through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_acc & ~addr_ok;
    end
  end

  // live value captured at the setup edge, stands until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rdata_d;
    end
  end

  // ***************************************
  // control register
  // ***************************************
  // writes land in one pclk cycle, far inside two slow cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_run_q <= 1'b1;
      wake_event_output_enable_q <= 1'b0;
    end else if (wr_ctl) begin
      count_run_q <= pwdata[`WAT_CTL_RUN_BIT];
      wake_event_output_enable_q <= pwdata[`WAT_CTL_WAKE_EN_BIT];
    end
  end

  // ***************************************
  // match and mask registers
  // ***************************************
  // match ignores count_run, so it can be set up while stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= `WAT_RST_MATCH;
    end else if (wr_mat) begin
      match_q <= pwdata[27:0];
    end
  end

  // only the two defined mask bits are stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `WAT_RST_IRQ_MASK;
    end else if (wr_msk) begin
      irq_mask_q <= pwdata[`WAT_IRQ_WIDTH-1:0];
    end
  end

  // ***************************************
  // prescale counter
  // ***************************************
  // forced to zero while stopped, the idle state of the timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= `WAT_RST_PRESCALE;
      step_q <= 1'b0;
    end else if (!count_run_q) begin
      prescale_q <= 15'h0000;
      step_q <= 1'b0;
    end else begin
      step_q <= slow_tick & (prescale_q == 15'h0000);
      if (slow_tick) begin
        // natural 15-bit wrap from max to zero ends each second
        prescale_q <= (prescale_q == `WAT_PRESCALE_MAX) ? 15'h0000 :
                      prescale_q + 15'h0001;
      end
    end
  end

  // ***************************************
  // seconds counter and pending write
  // ***************************************
  // while running, a write is parked and applied on the next step, so it never races the increment
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `WAT_RST_COUNT;
      pend_count_q <= `WAT_RST_COUNT;
      pend_valid_q <= 1'b0;
    end else begin
      if (wr_cnt) begin
        pend_count_q <= pwdata[27:0];
        pend_valid_q <= 1'b1;
      end else if (sec_step | ~count_run_q) begin
        pend_valid_q <= 1'b0;
      end
      if (sec_step) begin
        count_q <= pend_valid_q ? pend_count_q : count_q + 28'h0000001;
      end else if (~count_run_q & pend_valid_q) begin
        // stopped: no increment to race, so a parked write lands at once
        count_q <= pend_count_q;
      end
      // otherwise the count holds its value
    end
  end

  // ***************************************
  // compare
  // ***************************************
  // registered compare keeps the wide comparator off the output path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= (count_q >= match_q);
    end
  end

  // ***************************************
  // wake event and wake status
  // ***************************************
  // enable low holds the whole wake path in reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_q <= 1'b0;
    end else if (!wake_event_output_enable_q) begin
      wake_event_q <= 1'b0;
    end else begin
      wake_event_q <= alarm_q;
    end
  end

  // sticky wake status; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_status_q <= 1'b0;
    end else if (!wake_event_output_enable_q) begin
      wake_status_q <= 1'b0;
    end else if (alarm_q) begin
      wake_status_q <= 1'b1;
    end else if (wr_wks & pwdata[0]) begin
      wake_status_q <= 1'b0;
    end
  end

  // ***************************************
  // interrupt output
  // ***************************************
  // level output, high while any unmasked sticky flag is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_flags & irq_mask_q);
    end
  end
endmodule

`default_nettype wire

// >>> wat_core_assertions.sv
// port-level assertions for the week alarm timer core
`default_nettype none
module wat_core_assertions #(
  parameter SLOW_DIV = 1 // same as the core
) (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // select
  input wire penable, // access phase
  input wire pwrite, // direction
  input wire [11:0] paddr, // address
  input wire [31:0] pwdata, // write data
  input wire [3:0] pstrb, // strobes
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire irq_q, // interrupt
  input wire wake_event_q // wake event
);
  logic run_q;
  logic wen_q;
  logic msk_q;
  wire acc = psel && penable;
  wire rdacc = acc && !pwrite;
  wire mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 && paddr[4:2] != 3'h7;
  // shadows of run, wake enable and mask, since no register is visible here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b1;
      wen_q <= 1'b0;
      msk_q <= 1'b0;
    end else if (acc && pwrite && pstrb[0]) begin
      if (paddr == 12'h000) begin
        run_q <= pwdata[0];
        wen_q <= pwdata[6];
      end
      if (paddr == 12'h014) begin
        msk_q <= |pwdata[1:0];
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; acc && mapped |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_ctl; rdacc && paddr == 12'h000 |-> prdata[31:7] == 25'h0 && prdata[5:1] == 5'h0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control reserved bits set");
  property p_cnt; rdacc && (paddr == 12'h004 || paddr == 12'h008) |-> prdata[31:28] == 4'h0;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count or match upper bits set");
  property p_pre; rdacc && paddr == 12'h00c |-> prdata[31:15] == 17'h0; endproperty
  a_pre: assert property (p_pre) else $error("prescale upper bits set");
  // three cycles of margin for the stop write to land
  property p_stop;
    rdacc && paddr == 12'h00c && !run_q && $past(run_q, 3) == 1'b0 |-> prdata[14:0] == 15'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("prescale not zero while stopped");
  property p_wake;
    !wen_q && $past(wen_q) == 1'b0 && $past(wen_q, 2) == 1'b0 |-> !wake_event_q;
  endproperty
  a_wake: assert property (p_wake) else $error("wake high while disabled");
  property p_irq; !msk_q && $past(msk_q) == 1'b0 && $past(msk_q, 2) == 1'b0 |-> !irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt high while masked");
endmodule
bind wat_core wat_core_assertions #(.SLOW_DIV(SLOW_DIV)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_q(irq_q),
  .wake_event_q(wake_event_q));
`default_nettype wire

// >>> test_wat_core.sv
// self-checking bench for the week alarm timer core
`default_nettype none
module test_wat_core;
  timeunit 1ns;
  timeprecision 1ps;
  // one pclk per slow step keeps a second at 32768 cycles
  localparam int DIV = 1;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, irq_q, wake_event_q;
  int n_mismatch = 0;
  int compares = 0;
  wat_core #(.SLOW_DIV(DIV)) u_wat_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_q(irq_q),
    .wake_event_q(wake_event_q));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ***********************
  // tasks
  // ***********************
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog: the run needs about 33000 cycles
  initial begin
    #300000;
    n_mismatch++;
    wrap_up;
  end
  // ***********************
  // tests
  // ***********************
  initial begin
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h000, 32'h1, "control");
    rdchk(12'h008, 32'h0ffffff, "match");
    rdchk(12'h014, 32'h0, "mask");
    rdchk(12'h01c, 32'h0, "unmapped");
    chk("unmapped error", 32'h1, err);
    xfer(1'b1, 12'h000, 32'hffffff80);
    rdchk(12'h000, 32'h0, "control reserved");
    xfer(1'b1, 12'h00c, 32'h1234);
    rdchk(12'h00c, 32'h0, "prescale stopped");
    // the first prescale step after reset has already advanced the count once
    rdchk(12'h004, 32'h1, "count stopped");
    xfer(1'b1, 12'h008, 32'h3);
    xfer(1'b1, 12'h014, 32'h1);
    xfer(1'b1, 12'h000, 32'h41);
    // restart steps the count to 2 at once; 3 needs a full second of steps
    n = 0;
    while (irq_q !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk("second length", 32'h1, {31'h0, (n >= 32768 && n <= 32780)});
    repeat (3) @(posedge pclk);
    chk("irq", 32'h1, irq_q);
    chk("wake", 32'h1, wake_event_q);
    rdchk(12'h004, 32'h3, "count one second");
    rdchk(12'h010, 32'h3, "irq status");
    rdchk(12'h018, 32'h1, "wake status");
    xfer(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge pclk);
    chk("wake disabled", 32'h0, wake_event_q);
    rdchk(12'h018, 32'h0, "wake status disabled");
    xfer(1'b1, 12'h008, 32'h0ffffff);
    xfer(1'b1, 12'h010, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, irq_q);
    rdchk(12'h010, 32'h0, "irq status cleared");
    xfer(1'b1, 12'h000, 32'h0);
    repeat (50) @(posedge pclk);
    rdchk(12'h004, 32'h3, "count held");
    xfer(1'b1, 12'h004, 32'h10);
    rdchk(12'h004, 32'h10, "count written stopped");
    xfer(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge pclk);
    // resumes from the value written while stopped, stepped once as the prescaler leaves zero
    rdchk(12'h004, 32'h11, "count resumed");
    wrap_up;
  end
endmodule
`default_nettype wire
